// >>> verilog/ssta_regs.sv
// Scanner status and table access register bank on an Avalon-MM slave.
// Assumes image, fill and pause inputs come from same-clock logic; the sense
// and misc pins are asynchronous; table read data follows tbl_addr within a clock.
`timescale 1ns/1ps
module ssta_regs
  import ssta_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic sys_rst,
  // Avalon-MM slave.
  input wire logic [BUS_AW-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [AVS_DW-1:0] avs_writedata,
  input wire logic [AVS_DW/8-1:0] avs_byteenable,
  output logic [AVS_DW-1:0] avs_readdata,
  output logic avs_waitrequest,
  // Image buffer stream.
  input wire logic [DW-1:0] img_byte,
  input wire logic img_valid,
  output logic img_pop,
  // Buffer manager state.
  input wire logic [DW-1:0] fill_count,
  input wire logic scan_paused,
  // Sense and general purpose pins.
  input wire logic paper_detect_first,
  input wire logic paper_detect_second,
  input wire logic [IN_W-3:0] misc_io,
  // Correction table memory.
  output logic tbl_req,
  output logic tbl_we,
  output logic [1:0] tbl_target,
  output logic [1:0] tbl_colour,
  output logic [TBL_AW-1:0] tbl_addr,
  output logic [2*DW-1:0] tbl_wdata,
  input wire logic [2*DW-1:0] tbl_rdata,
  // Mode and interrupt.
  output logic mem_test_mode,
  output logic irq
);

  // ==========================================================
  // Bus handshake.

  ssta_bus_e state_q;
  ssta_bus_e state_d;
  logic wait_q;
  logic accept;
  logic [IDX_W-1:0] idx;
  logic aligned;
  logic wr_en;

  // A request is taken once, in the idle state; the ack state
  // lets the master see waitrequest low for exactly one edge.
  assign accept = (state_q == BUS_IDLE) && (avs_read || avs_write);
  assign idx = ssta_index(avs_address);
  assign aligned = ssta_aligned(avs_address);
  assign wr_en = accept && avs_write && avs_byteenable[0] && aligned;

  // Next state of the handshake.
  always_comb begin
    case (state_q)
      BUS_IDLE: state_d = accept ? BUS_ACK : BUS_IDLE;
      BUS_ACK: state_d = BUS_IDLE;
      default: state_d = BUS_IDLE;
    endcase
  end

  // Waitrequest is high at rest so nothing completes by accident.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= BUS_IDLE;
      wait_q <= 1'b1;
    end else begin
      state_q <= state_d;
      wait_q <= !accept;
    end
  end

  assign avs_waitrequest = wait_q;

  // ==========================================================
  // Access strobes.

  logic rd_any;
  logic rd_img;
  logic rd_stat;
  logic wr_ctrl;
  logic wr_ahi;
  logic wr_alo;
  logic wr_data;
  logic rd_data;
  logic wr_edge;
  logic wr_irqs;
  logic wr_irqm;

  // Misaligned reads return zero and trigger no side effect.
  assign rd_any = accept && avs_read && aligned;
  assign rd_img = rd_any && (idx == IDX_IMG);
  assign rd_stat = rd_any && (idx == IDX_STAT);
  assign rd_data = rd_any && (idx == IDX_DATA);
  assign wr_ctrl = wr_en && (idx == IDX_CTRL);
  assign wr_ahi = wr_en && (idx == IDX_AHI);
  assign wr_alo = wr_en && (idx == IDX_ALO);
  assign wr_data = wr_en && (idx == IDX_DATA);
  assign wr_edge = wr_en && (idx == IDX_EDGE);
  assign wr_irqs = wr_en && (idx == IDX_IRQS);
  assign wr_irqm = wr_en && (idx == IDX_IRQM);

  // ==========================================================
  // Image byte port.

  logic pop_q;

  // Each port read consumes one byte; an empty stream reads zero.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pop_q <= 1'b0;
    end else begin
      pop_q <= rd_img && img_valid;
    end
  end

  assign img_pop = pop_q;

  // ==========================================================
  // Input status.

  logic [IN_W-1:0] pins_s;
  logic [IN_W-1:0] prev_q;
  logic [IN_W-1:0] edge_q;
  logic [IN_W-1:0] edge_sel_q;
  logic [IN_W-1:0] rise;
  logic [IN_W-1:0] stat_view;

  ssta_sync #(
    .W(IN_W)
  ) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .d({misc_io, paper_detect_second, paper_detect_first}),
    .q(pins_s)
  );

  // Edge bits show a captured rising edge, level bits the pin now.
  assign rise = pins_s & ~prev_q;
  assign stat_view = (edge_q & edge_sel_q) | (pins_s & ~edge_sel_q);

  // A rise in the same cycle as a status read survives the clear,
  // so an edge is never lost between two polls.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      prev_q <= '0;
      edge_q <= '0;
    end else begin
      prev_q <= pins_s;
      edge_q <= (rd_stat ? '0 : edge_q) | rise;
    end
  end

  // ==========================================================
  // Table access control.

  logic [DW-1:0] ctrl_q;
  logic dir_rd;
  logic [DW-1:0] rbyte;
  logic gamma;

  ssta_tbl_if t ();

  ssta_tbl_seq u_seq (
    .clk(clk),
    .sys_rst(sys_rst),
    .t(t)
  );

  // Target, colour and test bits are plain storage.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_q <= CTL_RST;
    end else if (wr_ctrl) begin
      ctrl_q <= avs_writedata[DW-1:0];
    end
  end

  assign gamma = ctrl_q[CTL_TGT_LSB +: 2] == TGT_GAMMA;
  assign dir_rd = t.dir;

  // Window accesses against the direction bit are ignored, which
  // keeps a stray read from skipping a table entry.
  assign t.ld_hi = wr_ahi;
  assign t.ld_lo = wr_alo;
  assign t.acc = (rd_data && dir_rd) || (wr_data && !dir_rd);
  assign t.acc_wr = wr_data;
  assign t.wbyte = avs_writedata[DW-1:0];
  assign t.target = ctrl_q[CTL_TGT_LSB +: 2];

  // Coefficients read low byte first, then high byte.
  assign rbyte = (gamma || !t.phase) ? tbl_rdata[DW-1:0] : tbl_rdata[2*DW-1:DW];

  assign tbl_req = t.req;
  assign tbl_we = t.we;
  assign tbl_addr = t.oaddr;
  assign tbl_wdata = t.wdata;
  assign tbl_target = ctrl_q[CTL_TGT_LSB +: 2];
  assign tbl_colour = ctrl_q[CTL_COL_LSB +: 2];
  assign mem_test_mode = ctrl_q[CTL_TEST];

  // ==========================================================
  // Interrupts and edge configuration.

  logic [IN_W-1:0] edge_cfg_d;
  logic [IRQ_W-1:0] irq_stat_q;
  logic [IRQ_W-1:0] irq_mask_q;
  logic [IRQ_W-1:0] irq_ev;
  logic [IRQ_W-1:0] irq_clr;
  logic pause_prev_q;
  logic fill_prev_q;
  logic irq_q;

  // Events: pause entered, a rise on an edge-selected input, buffer became non-empty.
  assign irq_ev[IRQ_PAUSE] = scan_paused && !pause_prev_q;
  assign irq_ev[IRQ_EDGE] = |(rise & edge_sel_q);
  assign irq_ev[IRQ_DATA] = (fill_count != '0) && !fill_prev_q;
  assign irq_clr = wr_irqs ? avs_writedata[IRQ_W-1:0] : '0;
  assign edge_cfg_d = wr_edge ? avs_writedata[IN_W-1:0] : edge_sel_q;

  // Set wins over a write-one-to-clear in the same cycle.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_stat_q <= '0;
      irq_mask_q <= MASK_RST;
      edge_sel_q <= EDGE_RST;
      pause_prev_q <= 1'b0;
      fill_prev_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_ev;
      irq_mask_q <= wr_irqm ? avs_writedata[IRQ_W-1:0] : irq_mask_q;
      edge_sel_q <= edge_cfg_d;
      pause_prev_q <= scan_paused;
      fill_prev_q <= fill_count != '0;
      irq_q <= |(irq_stat_q & irq_mask_q);
    end
  end

  assign irq = irq_q;

  // ==========================================================
  // Read data.

  logic [DW-1:0] img_rd;
  logic [DW-1:0] ctrl_rd;
  logic [DW-1:0] ahi_rd;
  logic [DW-1:0] data_rd;
  logic [DW-1:0] rd_mux;
  logic [AVS_DW-1:0] rdata_q;

  // Reserved bits read as zero.
  assign img_rd = img_valid ? img_byte : '0;
  assign ctrl_rd = {1'b0, ctrl_q[CTL_TEST], 1'b0, scan_paused,
                    ctrl_q[CTL_COL_LSB +: 2], ctrl_q[CTL_TGT_LSB +: 2]};
  assign ahi_rd = {1'b0, t.dir, t.addr[TBL_AW-1:DW]};
  assign data_rd = dir_rd ? rbyte : '0;
  assign rd_mux = !aligned ? '0 :
                  (idx == IDX_IMG) ? img_rd :
                  (idx == IDX_FILL) ? fill_count :
                  (idx == IDX_STAT) ? stat_view :
                  (idx == IDX_CTRL) ? ctrl_rd :
                  (idx == IDX_AHI) ? ahi_rd :
                  (idx == IDX_ALO) ? t.addr[DW-1:0] :
                  (idx == IDX_DATA) ? data_rd :
                  (idx == IDX_EDGE) ? edge_sel_q :
                  (idx == IDX_IRQS) ? {{(DW-IRQ_W){1'b0}}, irq_stat_q} :
                  (idx == IDX_IRQM) ? {{(DW-IRQ_W){1'b0}}, irq_mask_q} :
                  '0;

  // Read data is caught at the accepting edge and held until the next.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_q <= '0;
    end else if (accept && avs_read) begin
      rdata_q <= {{(AVS_DW-DW){1'b0}}, rd_mux};
    end
  end

  assign avs_readdata = rdata_q;

  // ==========================================================
  // Checks.

  a_wait_single: assert property (
    @(posedge clk) disable iff (sys_rst)
    !avs_waitrequest |=> avs_waitrequest)
    else $error("Waitrequest stayed low for more than one cycle.");

  a_img_pop_cause: assert property (
    @(posedge clk) disable iff (sys_rst)
    img_pop |-> $past(rd_img) && $past(img_valid))
    else $error("Image byte popped without a port read.");

  a_img_read_data: assert property (
    @(posedge clk) disable iff (sys_rst)
    rd_img && img_valid |=> img_pop && avs_readdata[DW-1:0] == $past(img_byte))
    else $error("Image port read returned the wrong byte.");

  a_fill_read: assert property (
    @(posedge clk) disable iff (sys_rst)
    rd_any && idx == IDX_FILL |=> avs_readdata[DW-1:0] == $past(fill_count)
                                  && !avs_waitrequest)
    else $error("Fill count read did not match the buffer count.");

  a_stat_clear: assert property (
    @(posedge clk) disable iff (sys_rst)
    rd_stat && rise == '0 |=> edge_q == '0)
    else $error("Status read did not clear captured edges.");

  a_stat_set_wins: assert property (
    @(posedge clk) disable iff (sys_rst)
    rise != '0 |=> (edge_q & $past(rise)) == $past(rise))
    else $error("A sense edge was lost.");

  a_pause_flag: assert property (
    @(posedge clk) disable iff (sys_rst)
    rd_any && idx == IDX_CTRL |=> avs_readdata[CTL_PAUSE] == $past(scan_paused))
    else $error("Pause flag did not show the buffer-full state.");

  a_dir_gate: assert property (
    @(posedge clk) disable iff (sys_rst)
    (rd_data && !dir_rd) || (wr_data && dir_rd) |=> !tbl_req ##1 !tbl_req)
    else $error("Window access against the direction bit was used.");

  a_test_mode: assert property (
    @(posedge clk) disable iff (sys_rst)
    wr_ctrl |=> mem_test_mode == $past(avs_writedata[CTL_TEST]))
    else $error("Memory test mode did not follow the control write.");

  a_colour_sel: assert property (
    @(posedge clk) disable iff (sys_rst)
    wr_ctrl |=> tbl_colour == $past(avs_writedata[CTL_COL_LSB +: 2]))
    else $error("Colour select did not follow the control write.");

  a_irq_level: assert property (
    @(posedge clk) disable iff (sys_rst)
    (irq_stat_q & irq_mask_q) != '0 |=> irq)
    else $error("Interrupt not raised for an unmasked event.");

endmodule

// >>> verilog/ssta_pkg.sv
// Constants, field layout and types of the scanner status and table register bank.
// Assumes one clock domain; every design file of the bank except ssta_sync imports this package.
// Behaviour
// - Image port read returns next buffered byte.
// - Fill register reports buffered data count n.
// - Status shows inputs; read clears edge bits.
// - Pause flag reads one while buffer-full paused.
// - Table address: six high, eight low bits.
// - Data window uses current address, target, colour.
// - Address advances per byte or byte pair.
// - Memory test bit enables external memory test.
package ssta_pkg;
  // ==========================================================
  // Widths.
  localparam int unsigned DW = 8;
  localparam int unsigned AVS_DW = 32;
  localparam int unsigned BUS_AW = 6;
  localparam int unsigned IDX_W = 4;
  localparam int unsigned TBL_AW = 14;
  localparam int unsigned AHI_W = 6;
  localparam int unsigned IN_W = 8;
  localparam int unsigned IRQ_W = 3;
  // ==========================================================
  // Register indices; byte address is four times the index.
  localparam logic [IDX_W-1:0] IDX_IMG = 4'h0;
  localparam logic [IDX_W-1:0] IDX_FILL = 4'h1;
  localparam logic [IDX_W-1:0] IDX_STAT = 4'h2;
  localparam logic [IDX_W-1:0] IDX_CTRL = 4'h3;
  localparam logic [IDX_W-1:0] IDX_AHI = 4'h4;
  localparam logic [IDX_W-1:0] IDX_ALO = 4'h5;
  localparam logic [IDX_W-1:0] IDX_DATA = 4'h6;
  localparam logic [IDX_W-1:0] IDX_EDGE = 4'h8;
  localparam logic [IDX_W-1:0] IDX_IRQS = 4'h9;
  localparam logic [IDX_W-1:0] IDX_IRQM = 4'hA;
  // ==========================================================
  // Field positions.
  localparam int unsigned CTL_TGT_LSB = 0;
  localparam int unsigned CTL_COL_LSB = 2;
  localparam int unsigned CTL_PAUSE = 4;
  localparam int unsigned CTL_TEST = 6;
  localparam int unsigned AHI_DIR = 6;
  localparam int unsigned IRQ_PAUSE = 0;
  localparam int unsigned IRQ_EDGE = 1;
  localparam int unsigned IRQ_DATA = 2;
  // ==========================================================
  // Reset values.
  localparam logic [DW-1:0] CTL_RST = 8'h00;
  localparam logic [DW-1:0] EDGE_RST = 8'h00;
  localparam logic [IRQ_W-1:0] MASK_RST = 3'h0;
  localparam logic [TBL_AW-1:0] TADDR_RST = 14'h0000;
  // ==========================================================
  // Enumerations.
  typedef enum logic [1:0] {
    TGT_OFFSET = 2'h0,
    TGT_GAIN = 2'h1,
    TGT_GAMMA = 2'h2,
    TGT_UNUSED = 2'h3
  } ssta_target_e;
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK = 2'b10
  } ssta_bus_e;
  // ==========================================================
  // Address decoding shared by the bus logic.
  function automatic logic [IDX_W-1:0] ssta_index(input logic [BUS_AW-1:0] a);
    return a[BUS_AW-1:2];
  endfunction
  function automatic logic ssta_aligned(input logic [BUS_AW-1:0] a);
    return a[1:0] == 2'h0;
  endfunction
endpackage

// >>> verilog/ssta_tbl_if.sv
// Link between the register front end and the table access sequencer.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface ssta_tbl_if;
  import ssta_pkg::*;
  logic ld_hi;
  logic ld_lo;
  logic acc;
  logic acc_wr;
  logic [DW-1:0] wbyte;
  logic [1:0] target;
  logic [TBL_AW-1:0] addr;
  logic dir;
  logic phase;
  logic req;
  logic we;
  logic [TBL_AW-1:0] oaddr;
  logic [2*DW-1:0] wdata;
  modport ctl (output ld_hi, ld_lo, acc, acc_wr, wbyte, target,
               input addr, dir, phase, req, we, oaddr, wdata);
  modport seq (input ld_hi, ld_lo, acc, acc_wr, wbyte, target,
               output addr, dir, phase, req, we, oaddr, wdata);
endinterface

// >>> verilog/ssta_sync.sv
// Two-stage synchroniser for asynchronous input pins.
// Assumes the inputs are levels that stay put for several clocks.
`timescale 1ns/1ps
module ssta_sync #(
  parameter int unsigned W = 8
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic sys_rst,
  // Pins in, synchronised levels out.
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;
  // The first stage is read only by the second.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule

// >>> verilog/ssta_tbl_seq.sv
// Table access sequencer: address pointer, direction, byte pairing, table strobes.
// Assumes load and access strobes are single-cycle pulses from the front end.
`timescale 1ns/1ps
module ssta_tbl_seq
  import ssta_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic sys_rst,
  // Front end link.
  ssta_tbl_if.seq t
);
  logic wide;
  logic done;
  // Coefficients are sixteen bits wide and travel as a byte pair.
  assign wide = t.target != TGT_GAMMA;
  assign done = t.acc && !(wide && !t.phase);
  logic [DW-1:0] low_q;
  // Pointer, pairing phase and table strobes.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      t.addr <= TADDR_RST;
      t.dir <= 1'b0;
      t.phase <= 1'b0;
      t.req <= 1'b0;
      t.we <= 1'b0;
      t.oaddr <= TADDR_RST;
      t.wdata <= '0;
      low_q <= '0;
    end else begin
      t.req <= done;
      // The table address trails the pointer by one clock, so table read data belong to the
      // current entry from one clock after the pointer moves, and at a strobe to the accessed one.
      t.oaddr <= t.addr;
      if (t.ld_hi) begin
        t.addr[TBL_AW-1:DW] <= t.wbyte[AHI_W-1:0];
        t.dir <= t.wbyte[AHI_DIR];
        t.phase <= 1'b0;
      end else if (t.ld_lo) begin
        t.addr[DW-1:0] <= t.wbyte;
        t.phase <= 1'b0;
      end else if (done) begin
        t.addr <= TBL_AW'(t.addr + 1'b1);
        t.phase <= 1'b0;
        t.we <= t.acc_wr;
        t.wdata <= wide ? {t.wbyte, low_q} : {{DW{1'b0}}, t.wbyte};
      end else if (t.acc) begin
        t.phase <= 1'b1;
        low_q <= t.wbyte;
      end
    end
  end
  // ==========================================================
  // Checks.
  a_addr_advance: assert property (
    @(posedge clk) disable iff (sys_rst)
    done |=> t.addr == TBL_AW'($past(t.addr) + 1'b1) && t.req)
    else $error("Table address did not advance after a completed access.");
  a_pair_hold: assert property (
    @(posedge clk) disable iff (sys_rst)
    t.acc && wide && !t.phase && !t.ld_hi && !t.ld_lo |=> t.phase && $stable(t.addr))
    else $error("First byte of a coefficient moved the address.");
  a_write_strobe: assert property (
    @(posedge clk) disable iff (sys_rst)
    done && t.acc_wr |=> t.we && t.oaddr == $past(t.addr))
    else $error("Table write strobe carries the wrong address.");
  a_addr_load: assert property (
    @(posedge clk) disable iff (sys_rst)
    t.ld_hi |=> t.addr[TBL_AW-1:DW] == $past(t.wbyte[AHI_W-1:0])
                && t.dir == $past(t.wbyte[AHI_DIR]))
    else $error("High address load lost its value.");
endmodule

// >>> tb/tb_ssta_regs.sv
// Self-checking testbench for the scanner status and table register bank.
// Assumes the bank answers one bus request per two cycles and that table data
// follow tbl_addr combinationally; the bench models that table itself.
`timescale 1ns/1ps
module tb_ssta_regs;
  import ssta_pkg::*;
  // Clock, reset and bus.
  logic clk;
  logic sys_rst;
  logic [BUS_AW-1:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [AVS_DW-1:0] avs_writedata;
  logic [AVS_DW/8-1:0] avs_byteenable;
  logic [AVS_DW-1:0] avs_readdata;
  logic avs_waitrequest;
  // Stream, buffer state, pins and table.
  logic [DW-1:0] img_byte;
  logic img_valid;
  logic img_pop;
  logic [DW-1:0] fill_count;
  logic scan_paused;
  logic paper_detect_first;
  logic paper_detect_second;
  logic [IN_W-3:0] misc_io;
  logic tbl_req;
  logic tbl_we;
  logic [1:0] tbl_target;
  logic [1:0] tbl_colour;
  logic [TBL_AW-1:0] tbl_addr;
  logic [2*DW-1:0] tbl_wdata;
  logic [2*DW-1:0] tbl_rdata;
  logic mem_test_mode;
  logic irq;
  int fails;
  int cmp_count;
  int pops;
  int reqs;
  logic req_we;
  logic [TBL_AW-1:0] req_addr;
  logic [2*DW-1:0] req_wd;

  ssta_regs ssta_regs_inst (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .img_byte(img_byte), .img_valid(img_valid),
    .img_pop(img_pop), .fill_count(fill_count), .scan_paused(scan_paused),
    .paper_detect_first(paper_detect_first), .paper_detect_second(paper_detect_second),
    .misc_io(misc_io), .tbl_req(tbl_req), .tbl_we(tbl_we), .tbl_target(tbl_target),
    .tbl_colour(tbl_colour), .tbl_addr(tbl_addr), .tbl_wdata(tbl_wdata),
    .tbl_rdata(tbl_rdata), .mem_test_mode(mem_test_mode), .irq(irq));

  // ==========================================================
  // Table memory model: a pattern that differs per low address byte and per byte.
  assign tbl_rdata = {tbl_addr[7:0], ~tbl_addr[7:0]};

  // Clock at 125 MHz.
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Pop and table strobes are one-cycle pulses, so they are counted every edge.
  always @(posedge clk) begin
    if (img_pop === 1'b1) pops++;
    if (tbl_req === 1'b1) begin
      reqs++;
      req_we = tbl_we;
      req_addr = tbl_addr;
      req_wd = tbl_wdata;
    end
  end

  // ==========================================================
  // Comparison and bus tasks.
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One Avalon transfer; held until waitrequest is sampled low.
  task automatic bus(input logic wr, input logic [BUS_AW-1:0] a, input logic [DW-1:0] d,
                     output logic [DW-1:0] rd);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_read <= ~wr;
    avs_write <= wr;
    avs_writedata <= {24'h000000, d};
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    rd = avs_readdata[7:0];
    if (n >= 50) chk("waitrequest", 16'h0001, 16'h0000);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [IDX_W-1:0] i, input logic [DW-1:0] d);
    logic [DW-1:0] x;
    bus(1'b1, {i, 2'b00}, d, x);
  endtask

  task automatic rdc(input string name, input logic [BUS_AW-1:0] a, input logic [DW-1:0] e);
    logic [DW-1:0] x;
    bus(1'b0, a, 8'h00, x);
    chk(name, {8'h00, x}, {8'h00, e});
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Watchdog: the whole sequence needs well under 2000 cycles.
  initial begin
    #200us;
    fails++;
    print_verdict();
  end

  // ==========================================================
  // Main sequence.
  initial begin
    sys_rst = 1'b1;
    avs_address = '0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = '0;
    avs_byteenable = 4'hF;
    img_byte = 8'h00;
    img_valid = 1'b0;
    fill_count = 8'h00;
    scan_paused = 1'b0;
    paper_detect_first = 1'b0;
    paper_detect_second = 1'b0;
    misc_io = 6'h00;
    fails = 0;
    cmp_count = 0;
    pops = 0;
    reqs = 0;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    // Reset state of control, pointer and outputs.
    rdc("ctrl rst", 6'h0C, 8'h00);
    rdc("addr hi rst", 6'h10, 8'h00);
    rdc("addr lo rst", 6'h14, 8'h00);
    chk("test mode rst", {15'h0000, mem_test_mode}, 16'h0000);
    $display("test reset done");
    // Image byte port: one pop per read, no pop without data.
    img_valid <= 1'b1;
    img_byte <= 8'hA5;
    rdc("image byte", 6'h00, 8'hA5);
    img_valid <= 1'b0;
    rdc("image empty", 6'h00, 8'h00);
    chk("pop count", pops[15:0], 16'h0001);
    // Fill count, read-only against writes.
    fill_count <= 8'h3C;
    wr(IDX_FILL, 8'hFF);
    rdc("fill count", 6'h04, 8'h3C);
    rdc("unmapped", 6'h1C, 8'h00);
    rdc("misaligned", 6'h05, 8'h00);
    $display("test image and fill done");
    // Status levels and an edge-selected input.
    paper_detect_first <= 1'b1;
    misc_io <= 6'h2A;
    wr(IDX_EDGE, 8'h02);
    repeat (5) @(posedge clk);
    rdc("status level", 6'h08, 8'hA9);
    paper_detect_second <= 1'b1;
    repeat (5) @(posedge clk);
    paper_detect_second <= 1'b0;
    repeat (5) @(posedge clk);
    rdc("status edge", 6'h08, 8'hAB);
    rdc("status cleared", 6'h08, 8'hA9);
    $display("test status done");
    // Pause flag follows the buffer-full state.
    scan_paused <= 1'b1;
    repeat (2) @(posedge clk);
    rdc("pause flag", 6'h0C, 8'h10);
    // Every target and colour plane, test mode on.
    for (int t = 0; t < 3; t++) begin
      for (int c = 0; c < 3; c++) begin
        wr(IDX_CTRL, 8'h40 | 8'(c << 2) | 8'(t));
        @(posedge clk);
        chk("target", {14'h0000, tbl_target}, 16'(t));
        chk("colour", {14'h0000, tbl_colour}, 16'(c));
        chk("test mode", {15'h0000, mem_test_mode}, 16'h0001);
      end
    end
    rdc("ctrl back", 6'h0C, 8'h5A);
    $display("test control done");
    // Gamma write at address 0x1234 set through both halves, then read back the pointer.
    wr(IDX_CTRL, 8'h02);
    chk("test mode off", {15'h0000, mem_test_mode}, 16'h0000);
    wr(IDX_AHI, 8'h12);
    wr(IDX_ALO, 8'h34);
    rdc("window dir write", 6'h18, 8'h00);
    chk("no read strobe", reqs[15:0], 16'h0000);
    wr(IDX_DATA, 8'h5A);
    @(posedge clk);
    chk("gamma req", reqs[15:0], 16'h0001);
    chk("gamma we", {15'h0000, req_we}, 16'h0001);
    chk("gamma addr", {2'b00, req_addr}, 16'h1234);
    chk("gamma wdata", req_wd, 16'h005A);
    rdc("ptr lo", 6'h14, 8'h35);
    rdc("ptr hi", 6'h10, 8'h12);
    // Gain write of a byte pair at the last legal coefficient address.
    wr(IDX_CTRL, 8'h01);
    wr(IDX_AHI, 8'h3F);
    wr(IDX_ALO, 8'hFF);
    wr(IDX_DATA, 8'h11);
    chk("half pair", reqs[15:0], 16'h0001);
    wr(IDX_DATA, 8'h22);
    @(posedge clk);
    chk("pair req", reqs[15:0], 16'h0002);
    chk("pair addr", {2'b00, req_addr}, 16'h3FFF);
    chk("pair wdata", req_wd, 16'h2211);
    rdc("wrap lo", 6'h14, 8'h00);
    $display("test table write done");
    // Gamma reads advance per byte.
    wr(IDX_CTRL, 8'h02);
    wr(IDX_AHI, 8'h40);
    wr(IDX_ALO, 8'h10);
    rdc("gamma rd0", 6'h18, 8'hEF);
    rdc("gamma rd1", 6'h18, 8'hEE);
    chk("rd we", {15'h0000, req_we}, 16'h0000);
    // Offset reads advance per pair, low byte first.
    wr(IDX_CTRL, 8'h00);
    wr(IDX_ALO, 8'h20);
    rdc("coef lo", 6'h18, 8'hDF);
    rdc("coef hi", 6'h18, 8'h20);
    rdc("coef ptr", 6'h14, 8'h21);
    rdc("dir back", 6'h10, 8'h40);
    $display("test table read done");
    // Interrupts: pause rise, edge and fill events, masked then cleared.
    rdc("irq status", 6'h24, 8'h07);
    chk("irq masked", {15'h0000, irq}, 16'h0000);
    wr(IDX_IRQM, 8'h04);
    repeat (2) @(posedge clk);
    chk("irq raised", {15'h0000, irq}, 16'h0001);
    wr(IDX_IRQS, 8'h07);
    repeat (2) @(posedge clk);
    chk("irq cleared", {15'h0000, irq}, 16'h0000);
    rdc("irq status clr", 6'h24, 8'h00);
    $display("test interrupt done");
    print_verdict();
  end
endmodule
